// File: completed_xfer_counter.sv
// 3-bit count of finished second-port dma operations
// assumes inc and dec are single-cycle pulses on clk
`timescale 1ns/100ps
`include "mode_bank_cfg.svh"
module completed_xfer_counter
	import mode_bank_pkg::*;
(
	input wire logic clk, // processor clock
	input wire logic resetn, // synchronous reset, active low
	input wire logic inc, // last transfer of a second-port dma
	input wire logic dec, // dma-count branch executed
	output donecnt_t count_q // completed transfers
);

	// saturating both ways so an overrun never wraps into a false low count
	always_ff @(posedge clk) begin
		if (!resetn) begin
			count_q <= `DONE_RESET;
		end else if (inc && !dec && count_q != `DONE_MAX) begin
			count_q <= count_q + 3'h1;
		end else if (dec && !inc && count_q != `DONE_RESET) begin
			count_q <= count_q - 3'h1;
		end
	end

endmodule

// File: mode_bank_cfg.svh
// constants for the mode set/clear bank: register offsets, field positions, resets
// assumes a 6-bit register address and 16-bit data from the processor core
`ifndef MODE_BANK_CFG_SVH
`define MODE_BANK_CFG_SVH

`define ADDR_W 6
`define DATA_W 16
`define MODE_SETCLEAR_ADDR 6'h2A
`define NEIGHBOUR_VIEW_ADDR 6'h2B

`define CTL_SEL_MSB 3
`define CTL_SEL_LSB 0
`define CTL_SET_BIT 7
`define CTL_SF_BIT 8

`define WR_RXSEL_BIT 9
`define WR_TXSEL_BIT 8

`define STAT_DONE_MSB 13
`define STAT_DONE_LSB 11
`define STAT_RX_MSB 7
`define STAT_RX_LSB 4
`define STAT_TX_MSB 3
`define STAT_TX_LSB 0

`define MODE_RESET 16'h0000
`define SF_RESET 1'b0
`define CNTSEL_RESET 1'b0
`define DONE_RESET 3'h0
`define DONE_MAX 3'h7
`define RDATA_RESET 16'h0000

`endif

// File: mode_bank_pkg.sv
// types and shared helpers for the mode set/clear bank
// assumes nothing beyond a 16-bit register word
package mode_bank_pkg;

	typedef logic [15:0] word_t;
	typedef logic [3:0] nibble_t;
	typedef logic [2:0] donecnt_t;

	// selector codes of the hidden mode bits
	typedef enum logic [3:0] {
		SEL_HEC_OMIT = 4'h0,
		SEL_CELL56 = 4'h1,
		SEL_RSVD2 = 4'h2,
		SEL_RSVD3 = 4'h3,
		SEL_FASTMEM_M1 = 4'h4,
		SEL_DMA_PLUS = 4'h5,
		SEL_PORT1_EE = 4'h6,
		SEL_PORT2_EE = 4'h7,
		SEL_PLL_TEST = 4'h8,
		SEL_HEADER_CHECK_8BIT_CIRCUIT_GP = 4'h9,
		SEL_TIMER2_RUN = 4'hA,
		SEL_TIMER1_RUN = 4'hB,
		SEL_RSVD12 = 4'hC,
		SEL_RSVD13 = 4'hD,
		SEL_RSVD14 = 4'hE,
		SEL_RSVD15 = 4'hF
	} mode_sel_t;

	function automatic word_t revBits(input word_t w);
		word_t r;
		r = 16'h0000;
		for (int i = 0; i < 16; i++) begin
			r[i] = w[15 - i];
		end
		return r;
	endfunction

	function automatic nibble_t pickCount(input logic selFull, input nibble_t busy,
		input nibble_t full);
		return selFull ? full : busy;
	endfunction

endpackage

// File: mode_config_setclear_bank.sv
// hidden mode bits written through a set/clear control byte, plus the
// alternate read view at the neighbouring register location
// assumes all inputs come from logic on clk; reads answer one cycle later
// Functional notes
// - control byte selects one mode bit
// - bit 7 sets or clears; trigger wins
// - bit 8 stored as special-features enable
// - bits 0,1: header check omit, cell length
// - bit 4: fast memory mode
// - bit 5: enhanced dma auto address update
// - bit 6: first port early end
// - bit 7: second port early end
// - bit 8: reserved test mode, stored only
// - bit 9: header check on gp register
// - bit 10: second timer runs
// - bit 11: first timer runs
// - enable clear: read bit-reversed fast memory
// - enable set: status view, reserved zero
// - bits 13:11 count completed second-port dmas
// - dma-count branch decrements that counter
// - bits 7:4 receive busy or full count
// - bits 3:0 transmit busy or full count
// - neighbour write bits 9,8 pick counters
`timescale 1ns/100ps
`include "mode_bank_cfg.svh"
module mode_config_setclear_bank
	import mode_bank_pkg::*;
(
	input wire logic clk, // processor clock, 100 MHz
	input wire logic resetn, // synchronous reset, active low
	input wire logic regWrite, // register write strobe
	input wire logic regRead, // register read strobe
	input wire logic [`ADDR_W-1:0] regAddr, // register location
	input word_t regWrData, // write data
	output word_t regRdData_q, // read data, one cycle after the strobe
	output logic regRdValid_q, // read data valid pulse
	input word_t fastmemData, // fast-memory data register contents
	input wire logic dma2LastXfer, // final transfer of a second-port dma
	input wire logic dmaCountBranch, // dma-count branch executed
	input nibble_t rxBusyCount, // utopia receiver busy counter
	input nibble_t rxFullCount, // utopia receiver full counter
	input nibble_t txBusyCount, // utopia transmitter busy counter
	input nibble_t txFullCount, // utopia transmitter full counter
	input word_t modeTrigger, // hardware set pulse per mode bit
	output logic hecOmit, // header check byte omitted
	output logic cell56, // 56-byte cells
	output logic fastmemMode1, // fast memory in mode 1
	output logic dmaPlusEn, // dma updates local address
	output logic port1EarlyEnd, // first dma port early end
	output logic port2EarlyEnd, // second dma port early end
	output logic pllTestMode, // reserved test mode bit
	output logic hec8OnGp, // header check circuit on gp register
	output logic timer2Run, // second interval timer running
	output logic timer1Run, // first interval timer running
	output logic specialEn, // special-features enable
	output donecnt_t doneCount // completed-transfer counter
);

	word_t modeBits_q;
	logic specialEn_q;
	logic rxSelFull_q;
	logic txSelFull_q;
	donecnt_t doneCount_q;
	word_t view;
	logic ctlWrite;
	logic nbrWrite;
	logic nbrRead;
	mode_sel_t ctlSel;
	word_t selMask;
	logic selStores;

	assign ctlWrite = regWrite && regAddr == `MODE_SETCLEAR_ADDR;
	assign nbrWrite = regWrite && regAddr == `NEIGHBOUR_VIEW_ADDR;
	assign nbrRead = regRead && regAddr == `NEIGHBOUR_VIEW_ADDR;
	assign ctlSel = mode_sel_t'(regWrData[`CTL_SEL_MSB:`CTL_SEL_LSB]);
	assign selMask = 16'h0001 << ctlSel;
	// the top two selectors are reserved outright, so nothing is stored there
	assign selStores = ctlSel != SEL_RSVD14 && ctlSel != SEL_RSVD15;

	// one bit changes per control byte; a hardware trigger beats a clear
	always_ff @(posedge clk) begin
		if (!resetn) begin
			modeBits_q <= `MODE_RESET;
		end else if (ctlWrite && selStores) begin
			if (regWrData[`CTL_SET_BIT]) begin
				modeBits_q <= modeBits_q | selMask | modeTrigger;
			end else begin
				modeBits_q <= (modeBits_q & ~selMask) | modeTrigger;
			end
		end else begin
			modeBits_q <= modeBits_q | modeTrigger;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			specialEn_q <= `SF_RESET;
		end else if (ctlWrite) begin
			specialEn_q <= regWrData[`CTL_SF_BIT];
		end
	end

	// count selects only exist while special features are on; otherwise the
	// upper byte of that write is reserved and is dropped
	always_ff @(posedge clk) begin
		if (!resetn) begin
			rxSelFull_q <= `CNTSEL_RESET;
			txSelFull_q <= `CNTSEL_RESET;
		end else if (nbrWrite && specialEn_q) begin
			rxSelFull_q <= regWrData[`WR_RXSEL_BIT];
			txSelFull_q <= regWrData[`WR_TXSEL_BIT];
		end
	end

	completed_xfer_counter u_doneCnt (
		.clk(clk),
		.resetn(resetn),
		.inc(dma2LastXfer),
		.dec(dmaCountBranch),
		.count_q(doneCount_q)
	);

	status_view_mux u_view (
		.specialEn(specialEn_q),
		.fastmemData(fastmemData),
		.doneCount(doneCount_q),
		.rxSelFull(rxSelFull_q),
		.txSelFull(txSelFull_q),
		.rxBusyCount(rxBusyCount),
		.rxFullCount(rxFullCount),
		.txBusyCount(txBusyCount),
		.txFullCount(txFullCount),
		.view(view)
	);

	// read data holds its last value between reads
	always_ff @(posedge clk) begin
		if (!resetn) begin
			regRdData_q <= `RDATA_RESET;
		end else if (nbrRead) begin
			regRdData_q <= view;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			regRdValid_q <= 1'b0;
		end else begin
			regRdValid_q <= nbrRead;
		end
	end

	assign hecOmit = modeBits_q[SEL_HEC_OMIT];
	assign cell56 = modeBits_q[SEL_CELL56];
	assign fastmemMode1 = modeBits_q[SEL_FASTMEM_M1];
	assign dmaPlusEn = modeBits_q[SEL_DMA_PLUS];
	assign port1EarlyEnd = modeBits_q[SEL_PORT1_EE];
	assign port2EarlyEnd = modeBits_q[SEL_PORT2_EE];
	assign pllTestMode = modeBits_q[SEL_PLL_TEST];
	assign hec8OnGp = modeBits_q[SEL_HEADER_CHECK_8BIT_CIRCUIT_GP];
	assign timer2Run = modeBits_q[SEL_TIMER2_RUN];
	assign timer1Run = modeBits_q[SEL_TIMER1_RUN];
	assign specialEn = specialEn_q;
	assign doneCount = doneCount_q;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	sequence s_setWrite;
		ctlWrite && selStores && regWrData[`CTL_SET_BIT];
	endsequence

	sequence s_clearWrite;
		ctlWrite && selStores && !regWrData[`CTL_SET_BIT] && !modeTrigger[ctlSel];
	endsequence

	sequence s_incOnly;
		dma2LastXfer && !dmaCountBranch && doneCount_q != `DONE_MAX;
	endsequence

	sequence s_decOnly;
		dmaCountBranch && !dma2LastXfer && doneCount_q != `DONE_RESET;
	endsequence

	sequence s_statusRead;
		nbrRead && specialEn_q;
	endsequence

	chk_set_selected: assert property (
		s_setWrite |=> modeBits_q[$past(ctlSel)] && hecOmit == modeBits_q[0]
	) else $error("selected mode bit not set");

	chk_clear_selected: assert property (
		s_clearWrite |=> !modeBits_q[$past(ctlSel)]
	) else $error("selected mode bit not cleared");

	chk_trigger_wins: assert property (
		ctlWrite && !regWrData[`CTL_SET_BIT] && modeTrigger[ctlSel] |=> modeBits_q[$past(ctlSel)]
	) else $error("trigger lost against a clear");

	chk_only_one_bit: assert property (
		ctlWrite |=> (((modeBits_q ^ $past(modeBits_q)) & ~$past(selMask)) & ~$past(modeTrigger))
			== 16'h0000
	) else $error("unselected mode bit changed");

	chk_bits_hold_idle: assert property (
		!ctlWrite && modeTrigger == 16'h0000 |=> $stable(modeBits_q)
	) else $error("mode bits moved without a write");

	chk_reserved_sel_ignored: assert property (
		ctlWrite && !selStores && modeTrigger == 16'h0000 |=> $stable(modeBits_q)
	) else $error("reserved selector changed a bit");

	chk_sf_capture: assert property (
		ctlWrite |=> specialEn == $past(regWrData[`CTL_SF_BIT])
	) else $error("special-features enable not captured");

	chk_reverse_view: assert property (
		nbrRead && !specialEn_q |=> regRdValid_q && regRdData_q == revBits($past(fastmemData))
	) else $error("bit-reversed view wrong");

	chk_status_reserved: assert property (
		s_statusRead |=> regRdData_q[15:14] == 2'h0 && regRdData_q[10:8] == 3'h0
	) else $error("status view reserved bits not zero");

	chk_status_done: assert property (
		s_statusRead |=> regRdData_q[`STAT_DONE_MSB:`STAT_DONE_LSB] == $past(doneCount_q)
	) else $error("status view counter field wrong");

	chk_counter_inc: assert property (
		s_incOnly |=> doneCount_q == $past(doneCount_q) + 3'h1
	) else $error("completed counter did not increment");

	chk_counter_dec: assert property (
		s_decOnly |=> doneCount_q == $past(doneCount_q) - 3'h1
	) else $error("completed counter did not decrement");

	chk_counter_still: assert property (
		!dma2LastXfer && !dmaCountBranch |=> $stable(doneCount_q)
	) else $error("completed counter moved on its own");

	chk_rx_select: assert property (
		s_statusRead |=> regRdData_q[`STAT_RX_MSB:`STAT_RX_LSB]
			== ($past(rxSelFull_q) ? $past(rxFullCount) : $past(rxBusyCount))
	) else $error("receive count field wrong");

	chk_tx_select: assert property (
		s_statusRead |=> regRdData_q[`STAT_TX_MSB:`STAT_TX_LSB]
			== ($past(txSelFull_q) ? $past(txFullCount) : $past(txBusyCount))
	) else $error("transmit count field wrong");

	chk_select_capture: assert property (
		nbrWrite && specialEn_q ##1 s_statusRead |=> regRdData_q[3:0]
			== ($past(regWrData[`WR_TXSEL_BIT], 2) ? $past(txFullCount) : $past(txBusyCount))
	) else $error("count select not taken from write");

	chk_timer_outputs: assert property (
		ctlWrite && ctlSel == SEL_TIMER2_RUN && regWrData[`CTL_SET_BIT] |=> timer2Run
	) else $error("second timer run bit not set");

	chk_timer2_clear: assert property (
		ctlWrite && !regWrData[`CTL_SET_BIT] && ctlSel == SEL_TIMER2_RUN
			&& !modeTrigger[SEL_TIMER2_RUN] |=> !timer2Run
	) else $error("second timer run bit not cleared");

	chk_timer1_set: assert property (
		ctlWrite && regWrData[`CTL_SET_BIT] && ctlSel == SEL_TIMER1_RUN |=> timer1Run
	) else $error("first timer run bit not set");

	chk_hec_set: assert property (
		ctlWrite && regWrData[`CTL_SET_BIT] && ctlSel == SEL_HEC_OMIT |=> hecOmit
	) else $error("header check omit bit not set");

	chk_cell_set: assert property (
		ctlWrite && regWrData[`CTL_SET_BIT] && ctlSel == SEL_CELL56 |=> cell56
	) else $error("cell length bit not set");

	chk_fastmem_set: assert property (
		ctlWrite && regWrData[`CTL_SET_BIT] && ctlSel == SEL_FASTMEM_M1 |=> fastmemMode1
	) else $error("fast memory mode bit not set");

	chk_dma_set: assert property (
		ctlWrite && regWrData[`CTL_SET_BIT] && ctlSel == SEL_DMA_PLUS |=> dmaPlusEn
	) else $error("enhanced dma bit not set");

	chk_port1_set: assert property (
		ctlWrite && regWrData[`CTL_SET_BIT] && ctlSel == SEL_PORT1_EE |=> port1EarlyEnd
	) else $error("first port early end bit not set");

	chk_port2_set: assert property (
		ctlWrite && regWrData[`CTL_SET_BIT] && ctlSel == SEL_PORT2_EE |=> port2EarlyEnd
	) else $error("second port early end bit not set");

	chk_pll_set: assert property (
		ctlWrite && regWrData[`CTL_SET_BIT] && ctlSel == SEL_PLL_TEST |=> pllTestMode
	) else $error("reserved test bit not stored");

	chk_header_check_8bit_circuit_set: assert property (
		ctlWrite && regWrData[`CTL_SET_BIT] && ctlSel == SEL_HEADER_CHECK_8BIT_CIRCUIT_GP |=> hec8OnGp
	) else $error("header check on gp bit not set");

	// a trigger must land whatever the control byte does in that cycle
	chk_trigger_sets: assert property (
		modeTrigger != 16'h0000 |=> (modeBits_q & $past(modeTrigger)) == $past(modeTrigger)
	) else $error("hardware trigger did not set its bit");

	chk_sf_holds: assert property (
		!ctlWrite |=> $stable(specialEn_q)
	) else $error("special-features enable moved without a write");

	chk_select_holds: assert property (
		!(nbrWrite && specialEn_q) |=> $stable(rxSelFull_q) && $stable(txSelFull_q)
	) else $error("count select moved without a write");

	chk_select_taken: assert property (
		nbrWrite && specialEn_q |=> rxSelFull_q == $past(regWrData[`WR_RXSEL_BIT])
			&& txSelFull_q == $past(regWrData[`WR_TXSEL_BIT])
	) else $error("count select not captured");

	chk_rx_capture: assert property (
		nbrWrite && specialEn_q ##1 s_statusRead |=> regRdData_q[7:4]
			== ($past(regWrData[`WR_RXSEL_BIT], 2) ? $past(rxFullCount) : $past(rxBusyCount))
	) else $error("receive select not taken from write");

	chk_read_answered: assert property (
		nbrRead |=> regRdValid_q
	) else $error("neighbour read not answered");

	chk_valid_pulse: assert property (
		!nbrRead |=> !regRdValid_q
	) else $error("read valid without a read");

	chk_data_holds: assert property (
		!nbrRead |=> $stable(regRdData_q)
	) else $error("read data moved without a read");

	// both events together cancel, so the count must stay put
	chk_counter_both: assert property (
		dma2LastXfer && dmaCountBranch |=> $stable(doneCount_q)
	) else $error("counter moved on simultaneous events");

	chk_counter_top: assert property (
		dma2LastXfer && !dmaCountBranch && doneCount_q == `DONE_MAX
			|=> doneCount_q == `DONE_MAX
	) else $error("counter wrapped past its top");

	chk_counter_floor: assert property (
		dmaCountBranch && !dma2LastXfer && doneCount_q == `DONE_RESET
			|=> doneCount_q == `DONE_RESET
	) else $error("counter wrapped below zero");

endmodule

// File: mode_config_setclear_bank_bench.sv
// self-checking bench for the mode set/clear bank
// assumes the core model drives the register bus and dmaCountBranch; the bench drives all else
`timescale 1ns/100ps
module mode_config_setclear_bank_bench;
	import mode_bank_pkg::*;
	logic clk, resetn, regWrite, regRead, regRdValid_q, dma2LastXfer, dmaCountBranch;
	logic hecOmit, cell56, fastmemMode1, dmaPlusEn, port1EarlyEnd, port2EarlyEnd;
	logic pllTestMode, hec8OnGp, timer2Run, timer1Run, specialEn, rdValid;
	logic [5:0] regAddr;
	word_t regWrData, regRdData_q, fastmemData, modeTrigger, rdData, expMode;
	nibble_t rxBusyCount, rxFullCount, txBusyCount, txFullCount;
	donecnt_t doneCount;
	int err_total, tests_run, cycles;
	mode_config_setclear_bank mode_config_setclear_bank_inst (.clk(clk), .resetn(resetn),
		.regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData),
		.regRdData_q(regRdData_q), .regRdValid_q(regRdValid_q), .fastmemData(fastmemData),
		.dma2LastXfer(dma2LastXfer), .dmaCountBranch(dmaCountBranch),
		.rxBusyCount(rxBusyCount), .rxFullCount(rxFullCount), .txBusyCount(txBusyCount),
		.txFullCount(txFullCount), .modeTrigger(modeTrigger), .hecOmit(hecOmit),
		.cell56(cell56), .fastmemMode1(fastmemMode1), .dmaPlusEn(dmaPlusEn),
		.port1EarlyEnd(port1EarlyEnd), .port2EarlyEnd(port2EarlyEnd),
		.pllTestMode(pllTestMode), .hec8OnGp(hec8OnGp), .timer2Run(timer2Run),
		.timer1Run(timer1Run), .specialEn(specialEn), .doneCount(doneCount));
	proc_core_model proc_core_model_inst (.clk(clk), .regWrite(regWrite), .regRead(regRead),
		.regAddr(regAddr), .regWrData(regWrData), .dmaCountBranch(dmaCountBranch),
		.regRdData_q(regRdData_q), .regRdValid_q(regRdValid_q));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// mode outputs packed at their selector positions; bits 2,3 have no output
	function automatic word_t modeVec();
		return {4'h0, timer1Run, timer2Run, hec8OnGp, pllTestMode, port2EarlyEnd,
			port1EarlyEnd, dmaPlusEn, fastmemMode1, 2'b00, cell56, hecOmit};
	endfunction
	task automatic chk(input word_t got, input word_t exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		if (err_total == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic t_reset();
		chk(modeVec(), 16'h0000);
		chk({12'h000, specialEn, doneCount}, 16'h0000);
		chk(regRdData_q, 16'h0000);
		chk({15'h0000, regRdValid_q}, 16'h0000);
	endtask
	task automatic t_modes();
		nibble_t sels[10] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB};
		expMode = 16'h0000;
		foreach (sels[i]) begin
			proc_core_model_inst.ctl(sels[i], 1'b1, 1'b0);
			expMode[sels[i]] = 1'b1;
			chk(modeVec(), expMode);
		end
		proc_core_model_inst.ctl(4'h3, 1'b0, 1'b1);
		chk(modeVec(), expMode);
		chk({15'h0000, specialEn}, 16'h0001);
		proc_core_model_inst.ctl(4'hF, 1'b0, 1'b1);
		chk(modeVec(), expMode);
		chk({15'h0000, specialEn}, 16'h0001);
		foreach (sels[i]) begin
			proc_core_model_inst.ctl(sels[i], 1'b0, 1'b0);
			expMode[sels[i]] = 1'b0;
			chk(modeVec(), expMode);
			chk({15'h0000, specialEn}, 16'h0000);
		end
	endtask
	task automatic t_trigger();
		// a hardware set in the same cycle beats the clear
		fork
			proc_core_model_inst.ctl(4'h5, 1'b0, 1'b0);
			begin
				@(posedge clk);
				modeTrigger <= 16'h0020;
				@(posedge clk);
				modeTrigger <= 16'h0000;
			end
		join
		chk(modeVec(), 16'h0020);
		proc_core_model_inst.ctl(4'h5, 1'b0, 1'b0);
	endtask
	task automatic t_reverse(input word_t val);
		@(posedge clk);
		fastmemData <= val;
		proc_core_model_inst.rd(rdData, rdValid);
		chk({rdValid, rdData[15:1]}, {1'b1, 15'(word_t'({<<{val}}) >> 1)});
		chk(rdData, word_t'({<<{val}}));
	endtask
	task automatic t_status(input word_t sel, input nibble_t rx, input nibble_t tx);
		proc_core_model_inst.wr(6'h2B, sel);
		proc_core_model_inst.rd(rdData, rdValid);
		chk(rdData, {8'h00, rx, tx});
	endtask
	task automatic pulses(input int n);
		repeat (n) begin
			@(posedge clk);
			dma2LastXfer <= 1'b1;
			@(posedge clk);
			dma2LastXfer <= 1'b0;
		end
		#1;
	endtask
	task automatic t_counter();
		pulses(3);
		proc_core_model_inst.rd(rdData, rdValid);
		chk({13'h0000, rdData[13:11]}, 16'h0003);
		proc_core_model_inst.branch();
		chk({13'h0000, doneCount}, 16'h0002);
		pulses(9);
		chk({13'h0000, doneCount}, 16'h0007);
		fork
			pulses(1);
			proc_core_model_inst.branch();
		join
		chk({13'h0000, doneCount}, 16'h0007);
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			err_total++;
			$display("MISMATCH %0t run took too long", $time);
			print_verdict();
		end
	end
	initial begin
		resetn = 1'b0;
		fastmemData = 16'h0000;
		dma2LastXfer = 1'b0;
		modeTrigger = 16'h0000;
		rxBusyCount = 4'h3;
		rxFullCount = 4'hA;
		txBusyCount = 4'h5;
		txFullCount = 4'hC;
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		#1;
		t_reset();
		t_modes();
		t_trigger();
		t_reverse(16'h0001);
		t_reverse(16'h1234);
		proc_core_model_inst.ctl(4'h2, 1'b0, 1'b1);
		t_status(16'h0000, 4'h3, 4'h5);
		t_status(16'h0300, 4'hA, 4'hC);
		t_status(16'h0100, 4'h3, 4'hC);
		t_counter();
		print_verdict();
	end
endmodule

// File: proc_core_model.sv
// processor core model: issues register writes, reads and dma-count branches
// assumes the bench calls its tasks and owns every other input of the bank
`timescale 1ns/100ps
module proc_core_model
	import mode_bank_pkg::*;
(
	input wire logic clk, // processor clock
	output logic regWrite, // write strobe
	output logic regRead, // read strobe
	output logic [5:0] regAddr, // register location
	output word_t regWrData, // write data
	output logic dmaCountBranch, // branch executed pulse
	input word_t regRdData_q, // read data
	input wire logic regRdValid_q // read valid pulse
);
	initial begin
		regWrite = 1'b0;
		regRead = 1'b0;
		regAddr = 6'h00;
		regWrData = 16'h0000;
		dmaCountBranch = 1'b0;
	end
	// released lines show the inverse so a stale value cannot pass as a match
	task automatic wr(input logic [5:0] a, input word_t d);
		@(posedge clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk);
		regWrite <= 1'b0;
		regAddr <= ~a;
		regWrData <= ~d;
		#1;
	endtask
	task automatic ctl(input nibble_t sel, input logic setBit, input logic sf);
		wr(6'h2A, {7'h00, sf, setBit, 3'h0, sel});
	endtask
	task automatic rd(output word_t d, output logic v);
		@(posedge clk);
		regRead <= 1'b1;
		regAddr <= 6'h2B;
		@(posedge clk);
		regRead <= 1'b0;
		regAddr <= 6'h14;
		#1;
		v = regRdValid_q;
		d = regRdData_q;
	endtask
	task automatic branch();
		@(posedge clk);
		dmaCountBranch <= 1'b1;
		@(posedge clk);
		dmaCountBranch <= 1'b0;
		#1;
	endtask
endmodule

// File: status_view_mux.sv
// builds the word seen at the neighbour read location
// purely combinational; the caller registers the result
`timescale 1ns/100ps
`include "mode_bank_cfg.svh"
module status_view_mux
	import mode_bank_pkg::*;
(
	input wire logic specialEn, // special-features enable
	input word_t fastmemData, // fast-memory data register
	input donecnt_t doneCount, // completed-transfer counter
	input wire logic rxSelFull, // receive view picks full counter
	input wire logic txSelFull, // transmit view picks full counter
	input nibble_t rxBusyCount, // receiver busy counter
	input nibble_t rxFullCount, // receiver full counter
	input nibble_t txBusyCount, // transmitter busy counter
	input nibble_t txFullCount, // transmitter full counter
	output word_t view // read data
);

	always_comb begin
		view = 16'h0000;
		if (!specialEn) begin
			view = revBits(fastmemData);
		end else begin
			// reserved bits stay zero
			view[`STAT_DONE_MSB:`STAT_DONE_LSB] = doneCount;
			view[`STAT_RX_MSB:`STAT_RX_LSB] = pickCount(rxSelFull, rxBusyCount, rxFullCount);
			view[`STAT_TX_MSB:`STAT_TX_LSB] = pickCount(txSelFull, txBusyCount, txFullCount);
		end
	end

endmodule
